// ===== pmx_port_mux.sv
`timescale 1ns/1ps
`include "pmx_regs.svh"

// Overview of operation
// [RULE1] every one of the 32 pins has a select bit; set means general-purpose
// [RULE2] select bits 31..21 and 15..0 reset to zero: peripheral functions
// [RULE3] select bits 20..16 reset to one: pins start as general-purpose inputs
// [RULE4] a set select bit overrides both primary and alternate functions
// [RULE5] per-pin pull-up enable, set after reset, cleared to disable
// [RULE6] per-pin pull-down enable, clear after reset, set to enable
// [RULE7] four configuration straps captured at boot and held afterwards
// [RULE8] host strap: 00 parallel slave, 01 master, 10 reserved, 11 serial slave
// [RULE9] in serial slave mode the configuration straps are ignored
// [RULE10] configuration straps sit on port pins 2 to 5, ascending
// [RULE11] general-purpose pins take direction and data from software, input readable

module pmx_port_mux #(
    parameter int N_PINS = 32
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // register port
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // primary and alternate peripherals
    input wire logic [N_PINS-1:0] PRI_OUT,
    input wire logic [N_PINS-1:0] PRI_OE,
    input wire logic [N_PINS-1:0] ALTERNATE_FUNCTION_OUT,
    input wire logic [N_PINS-1:0] ALTERNATE_FUNCTION_OE,
    input wire logic [N_PINS-1:0] ALTERNATE_FUNCTION_SEL,
    output logic [N_PINS-1:0] FUNC_IN,
    // pads
    input wire logic [N_PINS-1:0] PAD_IN,
    output logic [N_PINS-1:0] PAD_OUT,
    output logic [N_PINS-1:0] PAD_OE,
    output logic [N_PINS-1:0] PAD_PULLUP,
    output logic [N_PINS-1:0] PAD_PULLDOWN,
    // host interface strap pins
    input wire logic [1:0] HOST_STRAP_IN,
    // captured boot configuration
    output pmx_pkg::pmx_host_mode_t HOST_MODE,
    output logic [3:0] GENERAL_STRAP_INPUT,
    output logic STRAP_VALID
);
    import pmx_pkg::*;

// ----------------------------------------
// state
// ----------------------------------------
    typedef struct packed {
        logic [N_PINS-1:0] sel;
        logic [N_PINS-1:0] puen;
        logic [N_PINS-1:0] pden;
        logic [N_PINS-1:0] dir;
        logic [N_PINS-1:0] dout;
        logic [N_PINS-1:0] pad_s1;
        logic [N_PINS-1:0] pad_s2;
        logic [1:0] host_s1;
        logic [1:0] host_s2;
        logic [2:0] boot_cnt;
        logic boot_done;
        logic [1:0] host_mode;
        logic [3:0] gen_strap;
        logic [31:0] rdata;
    } pmx_state_t;

    pmx_state_t cur;
    pmx_state_t next_cur;
    pmx_boot_state_t boot_state;
    logic [N_PINS-1:0] strap_lock;
    logic [N_PINS-1:0] func_out;
    logic [N_PINS-1:0] func_oe;
    logic [3:0] strap_levels;
    logic [7:0] strap_word;

// ----------------------------------------
// boot strap capture
// ----------------------------------------
    assign boot_state = cur.boot_done ? PMX_ST_DONE : PMX_ST_WAIT;
    // straps pass the two-stage synchroniser before being caught
    assign strap_levels = cur.pad_s2[`PMX_STRAP_LSB +: `PMX_STRAP_W]; // [RULE10]

    always_comb begin
        strap_lock = '0;
        // strap pins held undriven until capture, so the board straps win
        if (!cur.boot_done) begin
            strap_lock[`PMX_STRAP_LSB +: `PMX_STRAP_W] = '1; // [RULE10]
        end
    end

    assign strap_word = {cur.boot_done,
                         (cur.host_mode == `PMX_HOST_SER_SLAVE),
                         cur.host_mode,
                         cur.gen_strap};

// ----------------------------------------
// next state
// ----------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.pad_s1 = PAD_IN;
        next_cur.pad_s2 = cur.pad_s1;
        next_cur.host_s1 = HOST_STRAP_IN;
        next_cur.host_s2 = cur.host_s1;
        next_cur.rdata = '0;

        case (boot_state)
            PMX_ST_WAIT: begin
                // wait lets the synchroniser fill with real pin levels
                if (cur.boot_cnt == `PMX_CAPTURE_CYC) begin
                    next_cur.boot_done = 1'b1;
                    next_cur.host_mode = cur.host_s2; // [RULE8]
                    if (cur.host_s2 == `PMX_HOST_SER_SLAVE) begin
                        next_cur.gen_strap = '0; // [RULE9]
                    end else begin
                        next_cur.gen_strap = strap_levels; // [RULE7]
                    end
                end else begin
                    next_cur.boot_cnt = cur.boot_cnt + 3'h1;
                end
            end
            PMX_ST_DONE: begin
                // captured values held until the next reset
                next_cur.boot_cnt = cur.boot_cnt;
            end
            default: begin
                next_cur.boot_done = 1'b0;
            end
        endcase

        if (REG_WR) begin
            case (REG_ADDR)
                `PMX_OFF_SEL: next_cur.sel = REG_WDATA[N_PINS-1:0]; // [RULE1]
                `PMX_OFF_PUEN: next_cur.puen = REG_WDATA[N_PINS-1:0]; // [RULE5]
                `PMX_OFF_PDEN: next_cur.pden = REG_WDATA[N_PINS-1:0]; // [RULE6]
                `PMX_OFF_DIR: next_cur.dir = REG_WDATA[N_PINS-1:0]; // [RULE11]
                `PMX_OFF_DOUT: next_cur.dout = REG_WDATA[N_PINS-1:0]; // [RULE11]
                default: next_cur.sel = cur.sel;
            endcase
        end

        if (REG_RD) begin
            case (REG_ADDR)
                `PMX_OFF_SEL: next_cur.rdata = 32'(cur.sel);
                `PMX_OFF_PUEN: next_cur.rdata = 32'(cur.puen);
                `PMX_OFF_PDEN: next_cur.rdata = 32'(cur.pden);
                `PMX_OFF_DIR: next_cur.rdata = 32'(cur.dir);
                `PMX_OFF_DOUT: next_cur.rdata = 32'(cur.dout);
                `PMX_OFF_DIN: next_cur.rdata = 32'(cur.pad_s2); // [RULE11]
                `PMX_OFF_STRAP: next_cur.rdata = 32'(strap_word);
                default: next_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

// ----------------------------------------
// registers
// ----------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cur <= '0;
            cur.sel <= N_PINS'(`PMX_RST_SEL); // [RULE2] [RULE3]
            cur.puen <= N_PINS'(`PMX_RST_PUEN); // [RULE5]
            cur.pden <= N_PINS'(`PMX_RST_PDEN); // [RULE6]
            cur.dir <= N_PINS'(`PMX_RST_DIR);
            cur.dout <= N_PINS'(`PMX_RST_DOUT);
        end else begin
            cur <= next_cur;
        end
    end

// ----------------------------------------
// per-pin muxing
// ----------------------------------------
    // alternate chosen per pin by its owner peripheral's control
    assign func_out = (ALTERNATE_FUNCTION_SEL & ALTERNATE_FUNCTION_OUT)
                    | (~ALTERNATE_FUNCTION_SEL & PRI_OUT);
    assign func_oe = (ALTERNATE_FUNCTION_SEL & ALTERNATE_FUNCTION_OE)
                   | (~ALTERNATE_FUNCTION_SEL & PRI_OE);

    genvar gi;
    generate
        for (gi = 0; gi < N_PINS; gi = gi + 1) begin : g_pin
            pmx_pin_cell u_cell (
                .sel(cur.sel[gi]),
                .dir(cur.dir[gi]),
                .dout(cur.dout[gi]),
                .strap_lock(strap_lock[gi]),
                .func_out(func_out[gi]),
                .func_oe(func_oe[gi]),
                .pad_out(PAD_OUT[gi]),
                .pad_oe(PAD_OE[gi])
            );
        end
    endgenerate

    // peripherals see nothing from a pin taken for general-purpose use
    assign FUNC_IN = cur.pad_s2 & ~cur.sel; // [RULE4]
    assign PAD_PULLUP = cur.puen; // [RULE5]
    assign PAD_PULLDOWN = cur.pden; // [RULE6]

// ----------------------------------------
// outputs
// ----------------------------------------
    assign REG_RDATA = cur.rdata;
    assign HOST_MODE = pmx_host_mode_t'(cur.host_mode);
    assign GENERAL_STRAP_INPUT = cur.gen_strap;
    assign STRAP_VALID = cur.boot_done;

endmodule

// ===== pmx_regs.svh
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// ----------------------------------------
// register offsets (word index on the plain port)
// ----------------------------------------
`define PMX_OFF_SEL 4'h0
`define PMX_OFF_PUEN 4'h1
`define PMX_OFF_PDEN 4'h2
`define PMX_OFF_DIR 4'h3
`define PMX_OFF_DOUT 4'h4
`define PMX_OFF_DIN 4'h5
`define PMX_OFF_STRAP 4'h6

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMX_RST_SEL 32'h001F_0000
`define PMX_RST_PUEN 32'hFFFF_FFFF
`define PMX_RST_PDEN 32'h0000_0000
`define PMX_RST_DIR 32'h0000_0000
`define PMX_RST_DOUT 32'h0000_0000

// ----------------------------------------
// strap layout
// ----------------------------------------
`define PMX_STRAP_LSB 2
`define PMX_STRAP_W 4
`define PMX_HOST_W 2
`define PMX_STRAP_MODE_LSB 0
`define PMX_STRAP_HOST_LSB 4
`define PMX_STRAP_SERIAL_BIT 6
`define PMX_STRAP_VALID_BIT 7

// ----------------------------------------
// host strap codes
// ----------------------------------------
`define PMX_HOST_PAR_SLAVE 2'h0
`define PMX_HOST_MASTER 2'h1
`define PMX_HOST_RESERVED 2'h2
`define PMX_HOST_SER_SLAVE 2'h3

// ----------------------------------------
// boot capture count: STRAP_VALID rises one clock after boot_cnt reaches it, five cycles after reset release
// ----------------------------------------
`define PMX_CAPTURE_CYC 3'h4

`endif

// ===== pmx_pkg.sv
package pmx_pkg;

    `include "pmx_regs.svh"

    typedef enum logic [1:0] {
        PMX_PAR_SLAVE,
        PMX_MASTER,
        PMX_RESERVED,
        PMX_SER_SLAVE
    } pmx_host_mode_t;

    typedef enum {
        PMX_ST_WAIT,
        PMX_ST_DONE
    } pmx_boot_state_t;

endpackage

// ===== pmx_pin_cell.sv
`timescale 1ns/1ps

module pmx_pin_cell (
    // control
    input wire logic sel,
    input wire logic dir,
    input wire logic dout,
    input wire logic strap_lock,
    // peripheral side
    input wire logic func_out,
    input wire logic func_oe,
    // pad side
    output logic pad_out,
    output logic pad_oe
);

// ----------------------------------------
// one pin: general-purpose path beats peripheral path
// ----------------------------------------
    always_comb begin
        if (strap_lock) begin
            // strap pin stays quiet until its level has been caught
            pad_out = 1'b0;
            pad_oe = 1'b0;
        end else if (sel) begin // [RULE4]
            pad_out = dout; // [RULE11]
            pad_oe = dir; // [RULE11]
        end else begin
            pad_out = func_out;
            pad_oe = func_oe;
        end
    end

endmodule

// ===== pmx_port_mux_assertions.sv
`timescale 1ns/1ps
`include "pmx_regs.svh"
module pmx_chk
    import pmx_pkg::*;
#(
    parameter int N_PINS = 32
) (
    // clock, reset, register port
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    // pins
    input wire logic [N_PINS-1:0] PRI_OE,
    input wire logic [N_PINS-1:0] ALTERNATE_FUNCTION_OE,
    input wire logic [N_PINS-1:0] ALTERNATE_FUNCTION_SEL,
    input wire logic [N_PINS-1:0] PAD_IN,
    input wire logic [N_PINS-1:0] PAD_OE,
    input wire logic [N_PINS-1:0] PAD_PULLUP,
    input wire logic [N_PINS-1:0] PAD_PULLDOWN,
    // straps
    input wire logic [1:0] HOST_STRAP_IN,
    input wire pmx_host_mode_t HOST_MODE,
    input wire logic [3:0] GENERAL_STRAP_INPUT,
    input wire logic STRAP_VALID
);
    logic [31:0] sh [5];
    logic [N_PINS-1:0] fn_oe, exp_oe;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // shadow of the writable words, rebuilt from bus traffic alone
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sh <= '{`PMX_RST_SEL, `PMX_RST_PUEN, `PMX_RST_PDEN, `PMX_RST_DIR, `PMX_RST_DOUT};
        end else if (REG_WR && REG_ADDR < 4'h5) begin
            sh[REG_ADDR] <= REG_WDATA;
        end
    end

    // strap pins stay undriven until capture so the board level wins
    always_comb begin
        fn_oe = (ALTERNATE_FUNCTION_SEL & ALTERNATE_FUNCTION_OE)
              | (~ALTERNATE_FUNCTION_SEL & PRI_OE);
        exp_oe = (sh[0][N_PINS-1:0] & sh[3][N_PINS-1:0]) | (~sh[0][N_PINS-1:0] & fn_oe);
        if (!STRAP_VALID) begin
            exp_oe[5:2] = 4'h0;
        end
    end

    oe_mux_a: assert property (PAD_OE == exp_oe)
        else $error("pad enable wrong");
    pull_up_a: assert property (PAD_PULLUP == sh[1][N_PINS-1:0])
        else $error("pull-up wrong");
    pull_dn_a: assert property (PAD_PULLDOWN == sh[2][N_PINS-1:0])
        else $error("pull-down wrong");
    sel_read_a: assert property (REG_RD && REG_ADDR == 4'h0 |=> REG_RDATA == $past(sh[0]))
        else $error("select read wrong");
    strap_hold_a: assert property (STRAP_VALID |=> STRAP_VALID
        && $stable(GENERAL_STRAP_INPUT) && $stable(HOST_MODE))
        else $error("strap not held");
    cap_time_a: assert property ($fell(RST) |-> ##[1:8] STRAP_VALID)
        else $error("strap capture late");
    cap_mode_a: assert property ($rose(STRAP_VALID) |-> HOST_MODE == HOST_STRAP_IN)
        else $error("host mode wrong");
    cap_gen_a: assert property ($rose(STRAP_VALID) && HOST_MODE != PMX_SER_SLAVE
        |-> GENERAL_STRAP_INPUT == PAD_IN[5:2])
        else $error("general strap wrong");
    ser_ign_a: assert property (STRAP_VALID && HOST_MODE == PMX_SER_SLAVE
        |-> GENERAL_STRAP_INPUT == 4'h0)
        else $error("serial strap not ignored");

    cover property ($rose(STRAP_VALID) && HOST_MODE == PMX_SER_SLAVE);
    cover property (REG_WR && REG_ADDR == 4'h0);
    cover property (|(PAD_OE & sh[0]));
endmodule

bind pmx_port_mux pmx_chk #(.N_PINS(N_PINS)) i_pmx_chk (.CLK_SYS, .RST, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA, .PRI_OE, .ALTERNATE_FUNCTION_OE, .ALTERNATE_FUNCTION_SEL,
    .PAD_IN, .PAD_OE, .PAD_PULLUP, .PAD_PULLDOWN, .HOST_STRAP_IN, .HOST_MODE,
    .GENERAL_STRAP_INPUT, .STRAP_VALID);

// ===== tb_top.sv
`timescale 1ns/1ps
`include "pmx_regs.svh"
module tb_top;
    import pmx_pkg::*;
    logic clk = 0, rst = 1, wr = 0, rd = 0, sv;
    logic [3:0] addr = 0, gs, gx;
    logic [1:0] hs = 0, hh;
    logic [31:0] wd = 0, rdat, po = 0, poe = 0, ao = 0, aoe = 0, asl = 0, pin = 0;
    logic [31:0] fin, pout, poen, puo, pdo, g, sel, dir, dout, pu, pd, eo;
    logic [31:0] rv [5] = '{`PMX_RST_SEL, `PMX_RST_PUEN, `PMX_RST_PDEN,
                            `PMX_RST_DIR, `PMX_RST_DOUT};
    pmx_host_mode_t hm;
    int fails = 0, n_compared = 0, cyc = 0, k;

    pmx_port_mux i_pmx_port_mux (.CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .PRI_OUT(po), .PRI_OE(poe),
        .ALTERNATE_FUNCTION_OUT(ao), .ALTERNATE_FUNCTION_OE(aoe), .ALTERNATE_FUNCTION_SEL(asl),
        .FUNC_IN(fin), .PAD_IN(pin), .PAD_OUT(pout), .PAD_OE(poen), .PAD_PULLUP(puo),
        .PAD_PULLDOWN(pdo), .HOST_STRAP_IN(hs), .HOST_MODE(hm), .GENERAL_STRAP_INPUT(gs),
        .STRAP_VALID(sv));

    initial forever #5 clk = ~clk;

    // whole run needs about 930 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk);
        wr <= 0;
    endtask

    task automatic bus_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdat, e);
    endtask

    function automatic logic [31:0] mux(input logic [31:0] s, a, b);
        return (s & a) | (~s & b);
    endfunction

    task automatic results();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(8));
        for (int h = 0; h < 4; h++) begin
            hh = 2'(h);
            g = $urandom;
            gx = (hh == 2'h3) ? 4'h0 : g[5:2];
            @(posedge clk);
            rst <= 1;
            hs <= hh;
            pin <= g;
            repeat (16) @(posedge clk);
            rst <= 0;
            k = 0;
            while (sv !== 1'b1 && k < 20) begin
                @(posedge clk);
                #1 k++;
            end
            chk(32'(hm), 32'(hh));
            chk(32'(gs), 32'(gx));
            bus_rd(`PMX_OFF_STRAP, {24'h0, 1'b1, hh == 2'h3, hh, gx});
            @(posedge clk);
            pin <= ~g;
            hs <= ~hh;
            repeat (4) @(posedge clk);
            #1 chk(32'(gs), 32'(gx));
            $display("strap test %0d done", h);
        end
        for (int i = 0; i < 5; i++) bus_rd(4'(i), rv[i]);
        bus_rd(4'hF, 32'h0);
        bus_wr(`PMX_OFF_DIN, 32'hFFFF_FFFF);
        bus_rd(`PMX_OFF_DIN, ~g);
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            sel = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0 : $urandom;
            dir = $urandom;
            dout = $urandom;
            pu = $urandom;
            pd = $urandom;
            bus_wr(`PMX_OFF_SEL, sel);
            bus_wr(`PMX_OFF_DIR, dir);
            bus_wr(`PMX_OFF_DOUT, dout);
            bus_wr(`PMX_OFF_PUEN, pu);
            bus_wr(`PMX_OFF_PDEN, pd);
            po <= $urandom;
            poe <= $urandom;
            ao <= $urandom;
            aoe <= $urandom;
            asl <= $urandom;
            @(posedge clk);
            eo = mux(sel, dir, mux(asl, aoe, poe));
            #1 chk(poen, eo);
            chk(pout & eo, mux(sel, dout, mux(asl, ao, po)) & eo);
            chk(puo, pu);
            chk(pdo, pd);
            bus_rd(`PMX_OFF_SEL, sel);
            @(posedge clk);
            pin <= $urandom;
            // read data stands one cycle only, then returns to zero
            #1 chk(rdat, 32'h0);
            repeat (4) @(posedge clk);
            bus_rd(`PMX_OFF_DIN, pin);
            chk(fin, pin & ~sel);
        end
        $display("mux test done");
        results();
    end
endmodule
